//--- common/mdf_pkg.sv
// Shared constants and types for the motor drive fault monitor.
// Assumes a 100 MHz clock and 10-bit converter codes for current and bus voltage.
package mdf_pkg;
    // Clock and monitoring period
    localparam int CLK_MHZ = 100;
    localparam int MON_PERIOD_US = 100;
    localparam int MON_CYCLES = MON_PERIOD_US * CLK_MHZ;
    localparam int MON_CNT_W = 14;
    localparam logic [MON_CNT_W-1:0] MON_LAST = MON_CNT_W'(MON_CYCLES - 1);

    // Converter scaling: current -5 A..5 A over 0..3FF, so 1 A is 102.4 codes
    localparam int ADC_W = 10;
    localparam logic [ADC_W-1:0] CUR_ZERO = 10'h200;
    // 2 A over mid-scale: 204.8 codes, rounded down
    localparam logic [ADC_W-1:0] CUR_LIMIT_CODE = 10'h0CC;
    // Bus voltage 0..111 V over 0..3FF: 28 V is 258.3, 12 V is 110.7 codes
    localparam logic [ADC_W-1:0] OVERVOLT_CODE = 10'h102;
    localparam logic [ADC_W-1:0] UNDERVOLT_CODE = 10'h06E;

    // Speed in rpm
    localparam int SPEED_W = 16;
    localparam logic [SPEED_W-1:0] SPEED_LIMIT_RPM = 16'h09CA;

    // Fault flag positions
    localparam int FLT_HW_OC = 0;
    localparam int FLT_SW_OC = 1;
    localparam int FLT_OVERVOLT = 2;
    localparam int FLT_UNDERVOLT = 3;
    localparam int FLT_OVERSPEED = 4;
    localparam int FLT_RISE_OVF = 5;
    localparam int FLT_W = 6;
    localparam logic [FLT_W-1:0] FLT_RESET = 6'h00;

    typedef enum logic [1:0] {
        MDF_INACTIVE = 2'b00,
        MDF_ACTIVE = 2'b01,
        MDF_ERROR = 2'b10
    } mdf_mode_t;

    typedef struct packed {
        logic [ADC_W-1:0] cur_u;
        logic [ADC_W-1:0] cur_v;
        logic [ADC_W-1:0] cur_w;
        logic [ADC_W-1:0] bus_volt;
        logic [SPEED_W-1:0] speed_rpm;
    } mdf_meas_t;
endpackage

//--- hdl/mdf_tick.sv
// Monitoring period tick generator.
// Assumes the 100 MHz system clock; one pulse per monitoring period.
`timescale 1ns/100ps
module mdf_tick
(
    input wire logic clock_in,
    input wire logic rst_n_in,
    output logic tick_out
);
    logic [mdf_pkg::MON_CNT_W-1:0] count;
    wire at_last = (count == mdf_pkg::MON_LAST);

    always_ff @(posedge clock_in)
    begin
        if (!rst_n_in)
            count <= '0;
        else if (at_last)
            count <= '0;
        else
            count <= count + 1'b1;
    end

    always_ff @(posedge clock_in)
    begin
        if (!rst_n_in)
            tick_out <= 1'b0;
        else
            tick_out <= at_last;
    end
endmodule

//--- hdl/mdf_monitor.sv
// Motor drive fault monitor: latches protection faults and gates PWM.
// Assumes measurements are synchronous and held stable between updates.
// How it works
// - External overcurrent stop disables output at once
// - Each period, phase current above 2 A stops
// - Each period, bus above 28 V stops
// - Each period, bus below 12 V stops
// - Each period, speed above 2506 rpm stops
// - Rise time counter overflow stops output
// - Any single fault triggers the stop
// - Fault outside error mode raises error event, mode goes error
`timescale 1ns/100ps
module mdf_monitor
(
    input wire logic clock_in,
    input wire logic rst_n_in,
    input wire mdf_pkg::mdf_meas_t meas_in,
    input wire logic hw_oc_stop_in,
    input wire logic rise_time_counter_ovf_in,
    input wire logic drive_cmd_in,
    input wire logic stop_cmd_in,
    input wire logic reset_cmd_in,
    input wire logic pwm_req_in,
    output logic pwm_enable_out,
    output logic [mdf_pkg::FLT_W-1:0] fault_flags_out,
    output mdf_pkg::mdf_mode_t mode_out,
    output logic error_event_out,
    output logic mon_tick_out
);
    // Distance of a current sample from mid-scale
    function automatic logic [mdf_pkg::ADC_W-1:0] cur_mag(input logic [mdf_pkg::ADC_W-1:0] code);
        cur_mag = (code >= mdf_pkg::CUR_ZERO) ? code - mdf_pkg::CUR_ZERO
                                              : mdf_pkg::CUR_ZERO - code;
    endfunction

    logic tick;
    mdf_pkg::mdf_mode_t mode;
    mdf_pkg::mdf_mode_t next_mode;
    logic [mdf_pkg::FLT_W-1:0] flags;
    logic [mdf_pkg::FLT_W-1:0] next_flags;

    mdf_tick u_tick
    (
        .clock_in(clock_in),
        .rst_n_in(rst_n_in),
        .tick_out(tick)
    );

    // Each of the three phases gets its own magnitude compare, one copy per phase
    logic [mdf_pkg::ADC_W-1:0] phase_code [3];
    logic [2:0] phase_over;
    assign phase_code[0] = meas_in.cur_u;
    assign phase_code[1] = meas_in.cur_v;
    assign phase_code[2] = meas_in.cur_w;

    genvar ph;
    generate
        for (ph = 0; ph < 3; ph++)
        begin : g_phase
            assign phase_over[ph] = cur_mag(phase_code[ph]) > mdf_pkg::CUR_LIMIT_CODE;
        end
    endgenerate

    // Either current direction counts; the limit is on magnitude
    wire sw_oc = |phase_over;
    wire over_v = meas_in.bus_volt > mdf_pkg::OVERVOLT_CODE;
    wire under_v = meas_in.bus_volt < mdf_pkg::UNDERVOLT_CODE;
    wire over_s = meas_in.speed_rpm > mdf_pkg::SPEED_LIMIT_RPM;

    // New faults this cycle; periodic checks only count on the tick
    logic [mdf_pkg::FLT_W-1:0] detect;
    always_comb
    begin
        detect = '0;
        detect[mdf_pkg::FLT_HW_OC] = hw_oc_stop_in;
        detect[mdf_pkg::FLT_SW_OC] = tick && sw_oc;
        detect[mdf_pkg::FLT_OVERVOLT] = tick && over_v;
        detect[mdf_pkg::FLT_UNDERVOLT] = tick && under_v;
        detect[mdf_pkg::FLT_OVERSPEED] = tick && over_s;
        detect[mdf_pkg::FLT_RISE_OVF] = rise_time_counter_ovf_in;
    end

    wire any_detect = |detect;

    // Detection wins over a reset command in the same cycle
    assign next_flags = (reset_cmd_in ? mdf_pkg::FLT_RESET : flags) | detect;

    always_comb
    begin
        next_mode = mode;
        unique case (mode)
            mdf_pkg::MDF_INACTIVE:
                if (drive_cmd_in)
                    next_mode = mdf_pkg::MDF_ACTIVE;
            mdf_pkg::MDF_ACTIVE:
                if (stop_cmd_in)
                    next_mode = mdf_pkg::MDF_INACTIVE;
            mdf_pkg::MDF_ERROR:
                if (reset_cmd_in)
                    next_mode = mdf_pkg::MDF_INACTIVE;
            default:
                next_mode = mdf_pkg::MDF_ERROR;
        endcase
        if (any_detect)
            next_mode = mdf_pkg::MDF_ERROR;
    end

    always_ff @(posedge clock_in)
    begin
        if (!rst_n_in)
        begin
            flags <= mdf_pkg::FLT_RESET;
            mode <= mdf_pkg::MDF_INACTIVE;
            error_event_out <= 1'b0;
        end
        else
        begin
            flags <= next_flags;
            mode <= next_mode;
            error_event_out <= any_detect && (mode != mdf_pkg::MDF_ERROR);
        end
    end

    // Combinational gate so an external trip cuts PWM in the same cycle
    assign pwm_enable_out = pwm_req_in && (mode == mdf_pkg::MDF_ACTIVE)
                         && !any_detect && (flags == mdf_pkg::FLT_RESET);
    assign fault_flags_out = flags;
    assign mode_out = mode;
    assign mon_tick_out = tick;
endmodule

//--- verif/mdf_pwm_source.sv
// Power stage PWM demand model; toggles every clock so both gate states are seen.
`timescale 1ns/100ps
module mdf_pwm_source
(
    input wire logic clock_in,
    output logic pwm_req_out
);
    initial pwm_req_out = 1'h0;
    always @(posedge clock_in) pwm_req_out <= !pwm_req_out;
endmodule

//--- verif/mdf_monitor_checker.sv
// Port checks for mdf_monitor; one clock, synchronous reset.
`timescale 1ns/100ps
module mdf_monitor_checker
(
    input wire logic clock_in,
    input wire logic rst_n_in,
    input wire logic hw_oc_stop_in,
    input wire logic rise_time_counter_ovf_in,
    input wire logic reset_cmd_in,
    input wire logic pwm_enable_out,
    input wire logic [mdf_pkg::FLT_W-1:0] fault_flags_out,
    input wire mdf_pkg::mdf_mode_t mode_out,
    input wire logic error_event_out,
    input wire logic mon_tick_out
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (!rst_n_in);
    property p_hw; hw_oc_stop_in |-> !pwm_enable_out; endproperty
    a_hw: assert property (p_hw) else $error("hw gate");
    property p_hwf; hw_oc_stop_in |=> fault_flags_out[0]; endproperty
    a_hwf: assert property (p_hwf) else $error("hw flag");
    property p_ovo; rise_time_counter_ovf_in |-> !pwm_enable_out; endproperty
    a_ovo: assert property (p_ovo) else $error("ovf gate");
    property p_ovf; rise_time_counter_ovf_in |=> fault_flags_out[5]; endproperty
    a_ovf: assert property (p_ovf) else $error("ovf flag");
    property p_en; pwm_enable_out |-> mode_out == mdf_pkg::MDF_ACTIVE; endproperty
    a_en: assert property (p_en) else $error("gate mode");
    property p_err; |fault_flags_out |-> mode_out == mdf_pkg::MDF_ERROR; endproperty
    a_err: assert property (p_err) else $error("flag mode");
    property p_keep; fault_flags_out[0] && !reset_cmd_in |=> fault_flags_out[0]; endproperty
    a_keep: assert property (p_keep) else $error("flag lost");
    property p_clr; reset_cmd_in && !hw_oc_stop_in |=> !fault_flags_out[0]; endproperty
    a_clr: assert property (p_clr) else $error("flag kept");
    property p_evt; error_event_out |-> mode_out == mdf_pkg::MDF_ERROR; endproperty
    a_evt: assert property (p_evt) else $error("event mode");
    property p_tick; mon_tick_out |=> !mon_tick_out; endproperty
    a_tick: assert property (p_tick) else $error("tick width");
    cover property (hw_oc_stop_in);
    cover property (reset_cmd_in && fault_flags_out[0]);
    cover property (pwm_enable_out);
endmodule
bind mdf_monitor mdf_monitor_checker CHK (.*);

//--- verif/mdf_monitor_tb_top.sv
// Bench for mdf_monitor; limits and codes follow mdf_pkg.
`timescale 1ns/100ps
module mdf_monitor_tb_top;
    localparam mdf_pkg::mdf_meas_t N = '{10'h200, 10'h200, 10'h200, 10'h0C0, 16'h0100};
    logic clock_in = 1'h0, rst_n_in = 1'h0, hw_oc_stop_in = 1'h0, stop_cmd_in = 1'h0;
    logic rise_time_counter_ovf_in = 1'h0, drive_cmd_in = 1'h0, reset_cmd_in = 1'h0;
    logic pwm_req_in, pwm_enable_out, error_event_out, mon_tick_out;
    logic [mdf_pkg::FLT_W-1:0] fault_flags_out;
    mdf_pkg::mdf_mode_t mode_out;
    mdf_pkg::mdf_meas_t meas_in = N;
    int n_errors = 0, checks = 0, i;
    always #5 clock_in = !clock_in;
    mdf_pwm_source PART (.clock_in, .pwm_req_out(pwm_req_in));
    mdf_monitor DUT (.*);
    task cyc; @(posedge clock_in) #1; endtask
    task chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) n_errors++;
        if (got !== exp) $display("ERROR %0t %h %h", $time, got, exp);
    endtask
    task conclude;
        if (n_errors == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // Clear and start back to back, then one fault; limit faults wait for a tick
    task t_fault(input mdf_pkg::mdf_meas_t bad, input logic h, input logic o, input int b);
        {reset_cmd_in, drive_cmd_in} = 2'h2;
        cyc;
        {reset_cmd_in, drive_cmd_in} = 2'h1;
        cyc;
        drive_cmd_in = 1'h0;
        chk({mode_out, pwm_enable_out, fault_flags_out}, {2'h1, pwm_req_in, 6'h00});
        {meas_in, hw_oc_stop_in, rise_time_counter_ovf_in} = {bad, h, o};
        for (i = 0; i < 10100 && !(h | o) && mon_tick_out !== 1'h1; i++) cyc;
        #1 chk(pwm_enable_out, 1'h0);
        cyc;
        {meas_in, hw_oc_stop_in, rise_time_counter_ovf_in} = {N, 2'h0};
        chk({error_event_out, mode_out, fault_flags_out}, {3'h6, 6'h01 << b});
        cyc;
        chk({error_event_out, mode_out, fault_flags_out}, {3'h2, 6'h01 << b});
    endtask
    // Start then stop with no fault: gate must close and mode return to inactive
    task t_stop;
        {reset_cmd_in, drive_cmd_in} = 2'h2;
        cyc;
        {reset_cmd_in, drive_cmd_in} = 2'h1;
        cyc;
        {drive_cmd_in, stop_cmd_in} = 2'h1;
        cyc;
        stop_cmd_in = 1'h0;
        chk({mode_out, pwm_enable_out, fault_flags_out}, {2'h0, 1'h0, 6'h00});
    endtask
    initial
    begin
        repeat (6) cyc;
        rst_n_in = 1'h1;
        t_fault(N, 1'h1, 1'h0, 0);
        t_fault(N, 1'h0, 1'h1, 5);
        t_fault('{10'h200, 10'h133, 10'h200, 10'h0C0, 16'h0100}, 1'h0, 1'h0, 1);
        t_fault('{10'h200, 10'h200, 10'h200, 10'h103, 16'h0100}, 1'h0, 1'h0, 2);
        t_fault('{10'h200, 10'h200, 10'h200, 10'h06D, 16'h0100}, 1'h0, 1'h0, 3);
        t_fault('{10'h200, 10'h200, 10'h200, 10'h0C0, 16'h09CB}, 1'h0, 1'h0, 4);
        t_stop;
        conclude;
    end
    initial
    begin
        #700000 n_errors++;
        conclude;
    end
endmodule
